// ==== include/uic_pkg.sv ====
// Shared constants and carrier types for the serial-port interrupt and enable control
package uic_pkg;
    // Register port geometry
    localparam int unsigned UIC_AW = 3;
    localparam int unsigned UIC_DW = 8;

    // Register indexes on the plain register port
    localparam logic [2:0] UIC_CTRL = 3'h0;
    localparam logic [2:0] UIC_IE = 3'h1;
    localparam logic [2:0] UIC_FLAGS = 3'h2;
    localparam logic [2:0] UIC_RXBUF = 3'h3;
    localparam logic [2:0] UIC_TXBUF = 3'h4;

    // Control register field positions
    localparam int unsigned CB_SRST = 0;
    localparam int unsigned CB_RXEN = 1;
    localparam int unsigned CB_TXEN = 2;
    localparam int unsigned CB_ERRIE = 3;
    localparam int unsigned CB_ADDRF = 4;
    localparam int unsigned CB_SEDGE = 5;

    // Interrupt enable register field positions
    localparam int unsigned IB_RX = 0;
    localparam int unsigned IB_TX = 1;

    // Flag register field positions
    localparam int unsigned FB_RX = 0;
    localparam int unsigned FB_TX = 1;
    localparam int unsigned FB_EMPTY = 2;

    // Values after reset
    localparam logic SRST_RST = 1'b1;
    localparam logic TXFLAG_RST = 1'b1;
    localparam logic LINE_IDLE = 1'b1;

    // Character handed over by the receive shift engine
    typedef struct packed {
        logic valid;
        logic err;
        logic addr;
        logic [7:0] data;
    } uic_rx_ev_t;

    // Load strobe and character toward the transmit shift engine
    typedef struct packed {
        logic load;
        logic [7:0] data;
    } uic_tx_ld_t;
endpackage

// ==== rtl/uic_ctrl.sv ====
// Interrupt flag, interrupt enable and direction enable control of a serial port
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module uic_ctrl
    import uic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [UIC_AW-1:0] addr,
    input wire logic [UIC_DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [UIC_DW-1:0] rdata,
    // Processor interrupt side
    input wire logic global_irq_enable,
    input wire logic rx_irq_ack,
    input wire logic tx_irq_ack,
    output logic rx_irq,
    output logic tx_irq,
    // Receive shift engine
    input wire logic serial_rx_line,
    input wire logic rx_busy,
    input wire uic_rx_ev_t rx_ev,
    output logic rx_run,
    // Transmit shift engine
    input wire logic tx_shift_busy,
    output uic_tx_ld_t tx_ld
);
    logic srst_r, re_r, te_r, err_ie_r, addr_f_r, se_r;
    logic rx_ie_r, tx_ie_r, rx_flag_r, tx_flag_r, start_req_r;
    logic rx_run_r, rx_irq_r, tx_irq_r, te_prev_r;
    logic tx_full_r, tx_go_r;
    logic s1_r, s2_r, s3_r, line_r;
    logic [7:0] rx_buffer_r, tx_buffer_r;
    logic [UIC_DW-1:0] rdata_r;
    uic_tx_ld_t tx_ld_r;
    logic wr_ctrl, wr_ie, wr_tx, rd_rx, rx_store, rx_take, fall, load_now, tx_empty;

    // Register port decode
    assign wr_ctrl = wr && (addr == UIC_CTRL);
    assign wr_ie = wr && (addr == UIC_IE);
    assign wr_tx = wr && (addr == UIC_TXBUF);
    assign rd_rx = rd && (addr == UIC_RXBUF);

    // Receive qualification: filter first, then error gating
    assign rx_store = rx_ev.valid && rx_run_r && !srst_r
        && (!addr_f_r || rx_ev.addr);
    assign rx_take = rx_store && (!rx_ev.err || err_ie_r);

    // Transmit load: committed byte moves once the shifter is free
    assign load_now = tx_go_r && !tx_shift_busy && !tx_ld_r.load && !srst_r;
    assign tx_empty = !tx_full_r && !tx_shift_busy && !tx_ld_r.load;

    // Start edge on the filtered line
    assign fall = line_r && (s2_r == s3_r) && !s3_r;

    // Control register; direction enables ignore the soft reset bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            srst_r <= SRST_RST;
            re_r <= 1'b0;
            te_r <= 1'b0;
            err_ie_r <= 1'b0;
            addr_f_r <= 1'b0;
            se_r <= 1'b0;
        end else if (wr_ctrl) begin
            srst_r <= wdata[CB_SRST];
            re_r <= wdata[CB_RXEN];
            te_r <= wdata[CB_TXEN];
            err_ie_r <= wdata[CB_ERRIE];
            addr_f_r <= wdata[CB_ADDRF];
            se_r <= wdata[CB_SEDGE];
        end
    end

    // Interrupt enables, held clear under soft reset
    always_ff @(posedge clk) begin
        if (!rst_n || srst_r) begin
            rx_ie_r <= 1'b0;
            tx_ie_r <= 1'b0;
        end else if (wr_ie) begin
            rx_ie_r <= wdata[IB_RX];
            tx_ie_r <= wdata[IB_TX];
        end
    end

    // Three-stage line synchroniser with agreement filter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r <= LINE_IDLE;
            s2_r <= LINE_IDLE;
            s3_r <= LINE_IDLE;
            line_r <= LINE_IDLE;
        end else begin
            s1_r <= serial_rx_line;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                line_r <= s3_r;
            end
        end
    end

    // Receiver run: stays on only to finish a character in progress
    always_ff @(posedge clk) begin
        if (!rst_n || srst_r) begin
            rx_run_r <= 1'b0;
        end else begin
            rx_run_r <= re_r || (rx_busy && rx_run_r);
        end
    end

    // Hidden start-detect request
    always_ff @(posedge clk) begin
        if (!rst_n || srst_r || !se_r) begin
            start_req_r <= 1'b0;
        end else if (fall && re_r) begin
            start_req_r <= 1'b1;
        end
    end

    // Receive flag: set wins over read and service clears
    always_ff @(posedge clk) begin
        if (!rst_n || srst_r) begin
            rx_flag_r <= 1'b0;
        end else if (rx_take) begin
            rx_flag_r <= 1'b1;
        end else if (rd_rx || (rx_irq_ack && !se_r)) begin
            rx_flag_r <= 1'b0;
        end
    end

    // Receive buffer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_buffer_r <= 8'h00;
        end else if (rx_store) begin
            rx_buffer_r <= rx_ev.data;
        end
    end

    // Transmit buffer store; always writable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_buffer_r <= 8'h00;
        end else if (wr_tx) begin
            tx_buffer_r <= wdata[7:0];
        end
    end

    // Transmit buffer occupancy and commitment to send
    always_ff @(posedge clk) begin
        if (!rst_n || srst_r) begin
            tx_full_r <= 1'b0;
            tx_go_r <= 1'b0;
            te_prev_r <= 1'b0;
        end else begin
            te_prev_r <= te_r;
            if (wr_tx) begin
                tx_full_r <= 1'b1;
                tx_go_r <= te_r || tx_shift_busy || tx_ld_r.load;
            end else if (load_now) begin
                tx_full_r <= 1'b0;
                tx_go_r <= 1'b0;
            end else if (te_r && !te_prev_r) begin
                tx_go_r <= tx_full_r;
            end
        end
    end

    // Load strobe and character toward the shifter
    always_ff @(posedge clk) begin
        if (!rst_n || srst_r) begin
            tx_ld_r <= '0;
        end else begin
            tx_ld_r.load <= load_now;
            if (load_now) begin
                tx_ld_r.data <= tx_buffer_r;
            end
        end
    end

    // Transmit flag: set on buffer freed, beats write and service clears
    always_ff @(posedge clk) begin
        if (!rst_n || srst_r) begin
            tx_flag_r <= TXFLAG_RST;
        end else if (load_now) begin
            tx_flag_r <= 1'b1;
        end else if (wr_tx || tx_irq_ack) begin
            tx_flag_r <= 1'b0;
        end
    end

    // Two separate interrupt requests
    always_ff @(posedge clk) begin
        if (!rst_n || srst_r) begin
            rx_irq_r <= 1'b0;
            tx_irq_r <= 1'b0;
        end else begin
            rx_irq_r <= (rx_flag_r || start_req_r) && rx_ie_r && global_irq_enable;
            tx_irq_r <= tx_flag_r && tx_ie_r && global_irq_enable;
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n || !rd) begin
            rdata_r <= '0;
        end else begin
            unique case (addr)
                UIC_CTRL: rdata_r <= {2'h0, se_r, addr_f_r, err_ie_r, te_r, re_r, srst_r};
                UIC_IE: rdata_r <= {6'h00, tx_ie_r, rx_ie_r};
                UIC_FLAGS: rdata_r <= {5'h00, tx_empty, tx_flag_r, rx_flag_r};
                UIC_RXBUF: rdata_r <= rx_buffer_r;
                UIC_TXBUF: rdata_r <= tx_buffer_r;
                default: rdata_r <= '0;
            endcase
        end
    end

    // Outputs straight from flip-flops
    assign rdata = rdata_r;
    assign rx_irq = rx_irq_r;
    assign tx_irq = tx_irq_r;
    assign rx_run = rx_run_r;
    assign tx_ld = tx_ld_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_en_hold;
        !wr_ctrl |=> $stable(re_r) && $stable(te_r);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable moved without write");

    property p_rx_stop;
        !re_r && !rx_busy |=> !rx_run_r;
    endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("receiver kept running");

    property p_load_free;
        tx_ld_r.load |-> !$past(tx_shift_busy) && $past(tx_go_r);
    endproperty
    a_load_free: assert property (p_load_free) else $error("load into busy shifter");

    property p_idle_write;
        wr_tx && !te_r && !tx_shift_busy && !tx_ld_r.load && !srst_r |=> !tx_go_r ##1 !tx_ld_r.load;
    endproperty
    a_idle_write: assert property (p_idle_write) else $error("disabled write started send");

    property p_en_load;
        te_r && !te_prev_r && tx_full_r && !wr_tx && !srst_r && !tx_shift_busy
            && !tx_ld_r.load && !load_now |=> tx_go_r;
    endproperty
    a_en_load: assert property (p_en_load) else $error("enable did not commit buffer");

    property p_rx_set;
        rx_take |=> rx_flag_r;
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("receive set lost");

    property p_rx_read;
        rd_rx && !rx_take && !srst_r |=> !rx_flag_r;
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("read did not clear flag");

    property p_start_clr;
        !se_r |=> !start_req_r;
    endproperty
    a_start_clr: assert property (p_start_clr) else $error("start request survived");

    property p_tx_wr;
        wr_tx && !load_now && !srst_r |=> !tx_flag_r;
    endproperty
    a_tx_wr: assert property (p_tx_wr) else $error("write did not clear tx flag");

    property p_tx_irq;
        ##1 tx_irq_r == ($past(tx_flag_r) && $past(tx_ie_r) && $past(global_irq_enable)
            && !$past(srst_r));
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx request gating wrong");

    property p_rx_irq;
        rx_irq_r |-> $past(rx_ie_r) && $past(global_irq_enable);
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx request without enable");

    property p_srst;
        srst_r |=> tx_flag_r && !rx_flag_r && !rx_ie_r && !tx_ie_r && !tx_ld_r.load;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset not holding");
endmodule // uic_ctrl

// ==== verification/tb_top.sv ====
// Self-checking bench for the serial-port interrupt and enable control
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, got, exp); end end
module tb_top
    import uic_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = '0;
    logic [7:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] rdata;
    logic global_irq_enable = 1'b0;
    logic rx_irq_ack = 1'b0;
    logic tx_irq_ack = 1'b0;
    logic rx_irq;
    logic tx_irq;
    logic serial_rx_line = 1'b1;
    logic rx_busy;
    logic tx_shift_busy;
    logic rx_run;
    uic_rx_ev_t rx_ev;
    uic_tx_ld_t tx_ld;
    int failures = 0;
    int num_checks = 0;
    int seed = 69;
    logic [9:0] rq[$];
    logic [7:0] tq[$];
    logic vq[$];
    logic [9:0] exp_rd;
    logic [8:0] exp_ld;
    logic exp_run;

    uic_ctrl uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .global_irq_enable(global_irq_enable), .rx_irq_ack(rx_irq_ack),
        .tx_irq_ack(tx_irq_ack), .rx_irq(rx_irq), .tx_irq(tx_irq),
        .serial_rx_line(serial_rx_line),
        .rx_busy(rx_busy), .rx_ev(rx_ev), .rx_run(rx_run), .tx_shift_busy(tx_shift_busy),
        .tx_ld(tx_ld));
    uic_engine_model eng (.clk(clk), .tx_ld(tx_ld), .tx_shift_busy(tx_shift_busy),
        .rx_busy(rx_busy), .rx_ev(rx_ev));

    always #5 clk = ~clk;

    // Watcher: read results, transmit loads and receiver run state against the oldest note
    always @(posedge clk) begin
        rd_q <= rd;
        if (rd_q) begin
            exp_rd = rq.pop_front();
            `CHK({tx_irq, rx_irq, rdata}, exp_rd)
        end
        if (tx_ld.load) begin
            exp_ld = tq.size() ? {1'b1, tq.pop_front()} : 9'h000;
            `CHK({1'b1, tx_ld.data}, exp_ld)
        end
        if (rx_ev.valid) begin
            exp_run = vq.size() ? vq.pop_front() : 1'bx;
            `CHK(rx_run, exp_run)
        end
    end

    task automatic summarize();
        if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    // Expected value is {tx_irq, rx_irq, rdata}
    task automatic rd_reg(input logic [2:0] a, input logic [9:0] e);
        repeat (3) @(posedge clk);
        rq.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // Bounded wait until the shifter has been quiet for a while
    task automatic drain();
        int n;
        n = 0;
        for (int i = 0; i < 300 && n < 6; i++) begin
            @(posedge clk);
            n = (tx_shift_busy || tx_ld.load) ? 0 : n + 1;
        end
        if (n < 6) begin
            failures++;
            summarize();
        end
    endtask

    task automatic ack();
        rx_irq_ack <= 1'b1;
        @(posedge clk);
        rx_irq_ack <= 1'b0;
    endtask

    // Main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] x;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_reg(UIC_CTRL, 10'h001);
        rd_reg(UIC_FLAGS, 10'h006);
        rd_reg(3'h7, 10'h000);
        wr_reg(UIC_IE, 8'h03);
        rd_reg(UIC_IE, 10'h000);
        // Receive flag setting, error and address filtering
        wr_reg(UIC_CTRL, 8'h02);
        d = $random(seed);
        repeat (5) vq.push_back(1'b1);
        eng.send_char(d, 1'b0, 1'b0, 5);
        rd_reg(UIC_FLAGS, 10'h007);
        rd_reg(UIC_RXBUF, {2'b00, d});
        rd_reg(UIC_FLAGS, 10'h006);
        eng.send_char(d, 1'b1, 1'b0, 5);
        rd_reg(UIC_FLAGS, 10'h006);
        wr_reg(UIC_CTRL, 8'h0A);
        eng.send_char(d, 1'b1, 1'b0, 5);
        rd_reg(UIC_FLAGS, 10'h007);
        rd_reg(UIC_RXBUF, {2'b00, d});
        wr_reg(UIC_CTRL, 8'h12);
        eng.send_char(d, 1'b0, 1'b0, 5);
        rd_reg(UIC_FLAGS, 10'h006);
        eng.send_char(d, 1'b0, 1'b1, 5);
        wr_reg(UIC_IE, 8'h01);
        global_irq_enable <= 1'b1;
        rd_reg(UIC_FLAGS, 10'h107);
        ack();
        rd_reg(UIC_FLAGS, 10'h006);
        // Hidden start request
        wr_reg(UIC_CTRL, 8'h22);
        serial_rx_line <= 1'b0;
        repeat (6) @(posedge clk);
        serial_rx_line <= 1'b1;
        rd_reg(UIC_FLAGS, 10'h106);
        wr_reg(UIC_CTRL, 8'h02);
        rd_reg(UIC_FLAGS, 10'h006);
        // Transmit interrupt gating
        wr_reg(UIC_IE, 8'h03);
        rd_reg(UIC_FLAGS, 10'h206);
        global_irq_enable <= 1'b0;
        rd_reg(UIC_FLAGS, 10'h006);
        global_irq_enable <= 1'b1;
        wr_reg(UIC_IE, 8'h01);
        rd_reg(UIC_FLAGS, 10'h006);
        // Transmit service start clears the transmit flag
        tx_irq_ack <= 1'b1;
        @(posedge clk);
        tx_irq_ack <= 1'b0;
        rd_reg(UIC_FLAGS, 10'h004);
        // Disabled transmitter stores only; enabling sends the latest byte
        x = $random(seed);
        wr_reg(UIC_TXBUF, ~x);
        rd_reg(UIC_FLAGS, 10'h000);
        wr_reg(UIC_TXBUF, x);
        rd_reg(UIC_TXBUF, {2'b00, x});
        tq.push_back(x);
        wr_reg(UIC_CTRL, 8'h06);
        drain();
        // Disable with one byte shifting and one pending; both go out
        x = $random(seed);
        tq.push_back(x);
        wr_reg(UIC_TXBUF, x);
        rd_reg(UIC_FLAGS, 10'h002);
        tq.push_back(~x);
        wr_reg(UIC_TXBUF, ~x);
        wr_reg(UIC_CTRL, 8'h02);
        drain();
        rd_reg(UIC_FLAGS, 10'h006);
        // Receiver disabled mid-character finishes it, then ignores traffic
        d = $random(seed);
        vq.push_back(1'b1);
        fork
            eng.send_char(d, 1'b0, 1'b0, 10);
            begin
                @(posedge clk);
                wr_reg(UIC_CTRL, 8'h00);
            end
        join
        rd_reg(UIC_FLAGS, 10'h107);
        rd_reg(UIC_RXBUF, {2'b01, d});
        vq.push_back(1'b0);
        eng.send_char(~d, 1'b0, 1'b0, 5);
        rd_reg(UIC_FLAGS, 10'h006);
        // Soft reset keeps direction enables, clears interrupt enables and receive flag, sets transmit flag
        wr_reg(UIC_CTRL, 8'h07);
        rd_reg(UIC_CTRL, 10'h007);
        rd_reg(UIC_IE, 10'h000);
        rd_reg(UIC_FLAGS, 10'h006);
        summarize();
    end
endmodule // tb_top

// ==== verification/uic_engine_model.sv ====
// Behavioural serial shift engines on the far side of the control block
`timescale 1ns/1ps
module uic_engine_model
    import uic_pkg::*;
#(
    parameter int TX_BITS = 20
)
(
    // Clock
    input wire logic clk,
    // Transmit side
    input wire uic_tx_ld_t tx_ld,
    output logic tx_shift_busy,
    // Receive side
    output logic rx_busy,
    output uic_rx_ev_t rx_ev
);
    int tx_cnt = 0;

    // Shifter goes busy the cycle after a load and stays busy for one character
    always @(posedge clk) begin
        if (tx_ld.load) begin
            tx_cnt <= TX_BITS;
        end else if (tx_cnt > 0) begin
            tx_cnt <= tx_cnt - 1;
        end
    end
    assign tx_shift_busy = (tx_cnt > 0);

    initial begin
        rx_busy = 1'b0;
        rx_ev = '0;
    end

    // One character: busy for len cycles, then a single valid pulse
    task automatic send_char(input logic [7:0] d, input logic e, input logic a, input int len);
        rx_busy <= 1'b1;
        repeat (len) @(posedge clk);
        rx_busy <= 1'b0;
        rx_ev <= '{1'b1, e, a, d};
        @(posedge clk);
        rx_ev <= '{1'b0, ~e, ~a, ~d}; // Stale fields scrambled outside the pulse
    endtask
endmodule // uic_engine_model
